// >>> ifio_cfg.svh
// Register offsets, reset values and timing counts of the field I/O controller.
`ifndef IFIO_CFG_SVH
`define IFIO_CFG_SVH
`define IFIO_A_NV_BAUD 8'h00
`define IFIO_A_NV_UNIT 8'h04
`define IFIO_A_UNIT 8'h08
`define IFIO_A_NV_DOG 8'h0c
`define IFIO_A_DOG 8'h10
`define IFIO_A_OUT 8'h14
`define IFIO_A_IN 8'h18
`define IFIO_A_FAULT 8'h1c
`define IFIO_A_STATUS 8'h20
`define IFIO_A_SINK 8'h24
`define IFIO_A_SOURCE 8'h28
`define IFIO_A_SPIN 8'h2c
`define IFIO_A_PDMODE 8'h30
`define IFIO_A_ANA01 8'h34
`define IFIO_A_ANA23 8'h38
`define IFIO_A_BAUD 8'h3c
`define IFIO_A_CLEAR 8'h40
`define IFIO_DOG_DEF_MS 16'h0032
`define IFIO_BAUD_DEF 16'h0009
`define IFIO_CLK_HZ 40000000
`define IFIO_MS_NS 1000000
`define IFIO_CLK_NS 25
`define IFIO_CYC_PER_MS (`IFIO_MS_NS / `IFIO_CLK_NS)
`define IFIO_BLINK_CYC 24'h4c4b40
`define IFIO_F_WDOG 0
`define IFIO_F_SHORT 1
`define IFIO_F_OTEMP 2
`define IFIO_F_VHIGH 3
`define IFIO_F_VLOW 4
`define IFIO_F_VLOSS 5
`define IFIO_F_ALL 16'h003f
`define IFIO_HYST_HI 8'h3c
`define IFIO_HYST_LO 8'h28
`define IFIO_PCT 8'h64
`endif

// >>> ifio_pkg.sv
// Types shared by the field I/O controller.
package ifio_pkg;
  typedef enum logic [1:0] {IFIO_OFF, IFIO_SOURCE, IFIO_SINK, IFIO_PUSHPULL} ifio_mode_t;
  typedef struct packed {
    logic [15:0] hi_en;
    logic [15:0] lo_en;
  } ifio_drive_t;
  typedef struct packed {
    logic over_hi;
    logic under_lo;
    logic lost;
  } ifio_supply_t;
endpackage

// >>> ifio_top.sv
// Isolated field I/O controller with AXI4-Lite registers.
`timescale 1ns/1ps
`include "ifio_cfg.svh"
// Contract
// - Sink and source 16-bit masks per output.
// - Source one, sink zero gives sourcing.
// - Sink one, source zero gives sinking.
// - Both mask bits one gives push-pull.
// - Short trip disables that output, flags fault.
// - Over-temperature disables eight-output chip, flags fault.
// - Watchdog default 50 ms faults, disables outputs.
// - Output writes ignored while fault set.
// - Fault flag set out of power-up.
// - Watchdog in ms, zero disables it.
// - Non-volatile copied to working at power-up.
// - Baud index decodes to listed rates.
// - Spindle mode zero enable/direction, one forward/reverse.
// - Input high at 60%, low at 40%.
// - Inputs 0-3 analog, modes 1,2 only; the code also returns them in mode 3.
// - Field supply too high or low faults.
// - Report field loss with separate supply.
// - Sixteen-bit output word, bit per output.
// - Thirty-two-bit input word, bit per input.
// - Fault lamp until cleared, activity lamp blinks.
// - Process data mode selects transferred set.
module ifio_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] in_level_pct,
  input wire logic [255:0] in_pct_vec,
  input wire logic [31:0] ana_in,
  input wire logic [15:0] short_trip,
  input wire logic [1:0] otemp_warn,
  input wire logic field_supply_high,
  input wire logic field_supply_low,
  input wire logic field_supply_lost,
  input wire logic processor_supply_separate,
  input wire logic [7:0] field_supply_level,
  input wire logic [15:0] nv_baud_store,
  input wire logic [31:0] nv_unit_store,
  input wire logic [15:0] nv_dog_store,
  output ifio_pkg::ifio_drive_t drive,
  output logic [1:0] spindle_out,
  input wire logic spindle_enable,
  input wire logic spindle_reverse,
  output logic field_fault_indicator,
  output logic field_activity_indicator,
  output logic [23:0] baud_rate
);
  import ifio_pkg::*;

  logic [15:0] nv_baud_index_reg, nv_dog_period_reg, working_dog_period_reg;
  logic [31:0] nv_unit_id_reg, working_unit_id_reg, input_word_reg;
  logic [15:0] output_word_reg, fault_flags_reg, sink_mask_reg, source_mask_reg;
  logic [15:0] spindle_drive_mode_reg, short_off_reg;
  logic [1:0] otemp_off_reg, pd_mode_reg;
  logic [31:0] dog_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic [23:0] blink_cnt_reg;
  logic boot_reg, comm_seen_reg;
  logic [7:0] aw_addr_reg, ar_addr_reg;
  logic aw_have_reg, w_have_reg;
  logic [31:0] w_data_reg;
  logic wr_fire, rd_fire;
  logic fault_any, clear_hit;
  logic [15:0] out_en, fault_set, fault_clr;

  // Decode a baud index to its rate; unlisted indexes fall to the default rate.
  function automatic logic [23:0] baud_of(input logic [15:0] idx);
    case (idx)
      16'h0000: baud_of = 24'd9600;
      16'h0001: baud_of = 24'd19200;
      16'h0002: baud_of = 24'd38400;
      16'h0003: baud_of = 24'd57600;
      16'h0004: baud_of = 24'd115200;
      16'h0005: baud_of = 24'd230400;
      16'h0006: baud_of = 24'd460800;
      16'h0007: baud_of = 24'd921600;
      16'h0008: baud_of = 24'd1250000;
      16'h000a: baud_of = 24'd5000000;
      16'h000b: baud_of = 24'd10000000;
      default: baud_of = 24'd2500000;
    endcase
  endfunction

  // Merge a write strobe into an old 32-bit value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Write channels may arrive in either order; the response follows both.
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign fault_any = fault_flags_reg != 16'h0000;
  assign clear_hit = wr_fire && aw_addr_reg == `IFIO_A_CLEAR;
  assign out_en = ~short_off_reg & {{8{!otemp_off_reg[1]}}, {8{!otemp_off_reg[0]}}} &
                  {16{!fault_flags_reg[`IFIO_F_WDOG]}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg > `IFIO_A_CLEAR || aw_addr_reg[1:0] != 2'b00) ?
                       2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; working values load from non-volatile store at power-up.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_reg <= 1'b1;
      nv_baud_index_reg <= `IFIO_BAUD_DEF;
      nv_unit_id_reg <= 32'h0000_0000;
      working_unit_id_reg <= 32'h0000_0000;
      nv_dog_period_reg <= `IFIO_DOG_DEF_MS;
      working_dog_period_reg <= `IFIO_DOG_DEF_MS;
      sink_mask_reg <= 16'h0000;
      source_mask_reg <= 16'hffff;
      spindle_drive_mode_reg <= 16'h0000;
      pd_mode_reg <= 2'b00;
      output_word_reg <= 16'h0000;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        nv_baud_index_reg <= nv_baud_store;
        nv_unit_id_reg <= nv_unit_store;
        working_unit_id_reg <= nv_unit_store;
        nv_dog_period_reg <= nv_dog_store;
        working_dog_period_reg <= nv_dog_store;
      end else if (wr_fire) begin
        case (aw_addr_reg)
          `IFIO_A_NV_BAUD: nv_baud_index_reg <= w_data_reg[15:0];
          `IFIO_A_NV_UNIT: nv_unit_id_reg <= w_data_reg;
          `IFIO_A_UNIT: working_unit_id_reg <= w_data_reg;
          `IFIO_A_NV_DOG: nv_dog_period_reg <= w_data_reg[15:0];
          `IFIO_A_DOG: working_dog_period_reg <= w_data_reg[15:0];
          `IFIO_A_OUT: if (!fault_any) output_word_reg <= w_data_reg[15:0];
          `IFIO_A_SINK: sink_mask_reg <= w_data_reg[15:0];
          `IFIO_A_SOURCE: source_mask_reg <= w_data_reg[15:0];
          `IFIO_A_SPIN: spindle_drive_mode_reg <= w_data_reg[15:0];
          `IFIO_A_PDMODE: pd_mode_reg <= w_data_reg[1:0];
          default: ;
        endcase
      end
    end
  end

  // Watchdog counts milliseconds; any bus access restarts it, zero period stops it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_reg <= 16'h0000;
      dog_cnt_reg <= 32'h0000_0000;
      comm_seen_reg <= 1'b0;
    end else if (wr_fire || rd_fire) begin
      ms_cnt_reg <= 16'h0000;
      dog_cnt_reg <= 32'h0000_0000;
      comm_seen_reg <= 1'b1;
    end else if (working_dog_period_reg != 16'h0000) begin
      if (ms_cnt_reg == 16'(`IFIO_CYC_PER_MS - 1)) begin
        ms_cnt_reg <= 16'h0000;
        dog_cnt_reg <= dog_cnt_reg + 32'h1;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 16'h1;
      end
    end else begin
      ms_cnt_reg <= 16'h0000;
      dog_cnt_reg <= 32'h0000_0000;
    end
  end

  always_comb begin
    fault_set = 16'h0000;
    fault_clr = 16'h0000;
    fault_set[`IFIO_F_WDOG] = working_dog_period_reg != 16'h0000 &&
                              dog_cnt_reg >= {16'h0000, working_dog_period_reg};
    fault_set[`IFIO_F_SHORT] = |short_trip;
    fault_set[`IFIO_F_OTEMP] = |otemp_warn;
    fault_set[`IFIO_F_VHIGH] = field_supply_high;
    fault_set[`IFIO_F_VLOW] = field_supply_low;
    fault_set[`IFIO_F_VLOSS] = processor_supply_separate && field_supply_lost;
    if (clear_hit) begin
      fault_clr = w_data_reg[15:0] & `IFIO_F_ALL;
    end
  end

  // Fault latch; hardware set wins over a clear written in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_flags_reg <= 16'h0001;
      short_off_reg <= 16'h0000;
      otemp_off_reg <= 2'b00;
    end else begin
      fault_flags_reg <= (fault_flags_reg & ~fault_clr) | fault_set;
      if (clear_hit) begin
        short_off_reg <= short_trip;
        otemp_off_reg <= otemp_warn;
      end else begin
        short_off_reg <= short_off_reg | short_trip;
        otemp_off_reg <= otemp_off_reg | otemp_warn;
      end
    end
  end

  // Inputs with hysteresis: high at 60 percent, low again at 40 percent.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_word_reg <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (in_pct_vec[i*8 +: 8] >= `IFIO_HYST_HI) input_word_reg[i] <= 1'b1;
        else if (in_pct_vec[i*8 +: 8] <= `IFIO_HYST_LO) input_word_reg[i] <= 1'b0;
      end
    end
  end

  // Output drivers: mode from masks, forced off when disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else begin
      for (int n = 0; n < 16; n++) begin
        drive.hi_en[n] <= out_en[n] && source_mask_reg[n] && output_word_reg[n];
        drive.lo_en[n] <= out_en[n] && sink_mask_reg[n] &&
                          (output_word_reg[n] != source_mask_reg[n]);
      end
    end
  end

  // Spindle outputs, lamps and baud decode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spindle_out <= 2'b00;
      field_fault_indicator <= 1'b1;
      field_activity_indicator <= 1'b0;
      blink_cnt_reg <= 24'h000000;
      baud_rate <= baud_of(`IFIO_BAUD_DEF);
    end else begin
      if (spindle_drive_mode_reg == 16'h0000) begin
        spindle_out <= {spindle_reverse, spindle_enable};
      end else begin
        spindle_out <= {spindle_enable && spindle_reverse,
                        spindle_enable && !spindle_reverse};
      end
      field_fault_indicator <= fault_any || !comm_seen_reg;
      if (blink_cnt_reg == `IFIO_BLINK_CYC) begin
        blink_cnt_reg <= 24'h000000;
        field_activity_indicator <= comm_seen_reg && !field_activity_indicator;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 24'h1;
      end
      baud_rate <= baud_of(nv_baud_index_reg);
    end
  end

  // Read channel; analog data only in modes 1-3, second supply level byte only in mode 2, top byte always.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `IFIO_A_NV_BAUD: s_axi_rdata <= {16'h0000, nv_baud_index_reg};
          `IFIO_A_NV_UNIT: s_axi_rdata <= nv_unit_id_reg;
          `IFIO_A_UNIT: s_axi_rdata <= working_unit_id_reg;
          `IFIO_A_NV_DOG: s_axi_rdata <= {16'h0000, nv_dog_period_reg};
          `IFIO_A_DOG: s_axi_rdata <= {16'h0000, working_dog_period_reg};
          `IFIO_A_OUT: s_axi_rdata <= {16'h0000, output_word_reg};
          `IFIO_A_IN: s_axi_rdata <= input_word_reg;
          `IFIO_A_FAULT: s_axi_rdata <= {16'h0000, fault_flags_reg};
          `IFIO_A_STATUS: s_axi_rdata <= {field_supply_level,
                           (pd_mode_reg == 2'b10) ? field_supply_level : 8'h00,
                           4'h0, otemp_off_reg, comm_seen_reg, fault_any, short_off_reg[7:0]};
          `IFIO_A_SINK: s_axi_rdata <= {16'h0000, sink_mask_reg};
          `IFIO_A_SOURCE: s_axi_rdata <= {16'h0000, source_mask_reg};
          `IFIO_A_SPIN: s_axi_rdata <= {16'h0000, spindle_drive_mode_reg};
          `IFIO_A_PDMODE: s_axi_rdata <= {30'h0, pd_mode_reg};
          `IFIO_A_ANA01: s_axi_rdata <= (pd_mode_reg != 2'b00) ?
                           {16'h0000, ana_in[15:0]} : 32'h0;
          `IFIO_A_ANA23: s_axi_rdata <= (pd_mode_reg != 2'b00) ?
                           {16'h0000, ana_in[31:16]} : 32'h0;
          `IFIO_A_BAUD: s_axi_rdata <= {8'h00, baud_rate};
          `IFIO_A_CLEAR: s_axi_rdata <= 32'h0;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  AST_FAULT_BLOCKS_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_flags_reg[`IFIO_F_WDOG] |=> drive == '0) else $error("Outputs driven while faulted.");
  AST_NO_SHOOT_THROUGH: assert property (@(posedge aclk) disable iff (!aresetn)
    (drive.hi_en & drive.lo_en) == 16'h0000) else $error("Both drivers on at one output.");
  AST_SHORT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    short_trip[0] |=> ##1 !drive.hi_en[0]) else $error("Shorted output stayed on.");
  AST_OTEMP_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    |otemp_warn |=> fault_flags_reg[`IFIO_F_OTEMP]) else $error("No temp fault.");
  AST_DOG_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    working_dog_period_reg == 16'h0 |-> dog_cnt_reg == 32'h0)
    else $error("Watchdog ran while disabled.");
  AST_FAULT_LAMP: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_any |=> field_fault_indicator) else $error("Fault lamp dark.");
  AST_ANA_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && s_axi_araddr == `IFIO_A_ANA01 && pd_mode_reg == 2'b00 |=> s_axi_rdata == 32'h0)
    else $error("Analog read in mode zero.");
  AST_SINK_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    !source_mask_reg[0] |=> !drive.hi_en[0]) else $error("Sink output sourced.");
  AST_VOLT_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    field_supply_low |=> fault_flags_reg[`IFIO_F_VLOW]) else $error("No supply fault.");
endmodule // ifio_top

// >>> ifio_field_model.sv
// Field side model that turns input levels into percent codes.
`timescale 1ns/1ps
module ifio_field_model (
  input wire logic [7:0] lvl0,
  input wire logic [31:0] pat,
  output logic [255:0] in_pct_vec
);
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      in_pct_vec[8*n +: 8] = pat[n] ? 8'h50 : 8'h14;
    end
    in_pct_vec[7:0] = lvl0;
  end
endmodule // ifio_field_model

// >>> ifio_top_test.sv
// Self-checking testbench of the field I/O controller.
`timescale 1ns/1ps
`include "ifio_cfg.svh"
module ifio_top_test;
  import ifio_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sp_en = 0, sp_rev = 0, sep = 0;
  logic [7:0] awaddr = 0, araddr = 0, lvl0 = 0;
  logic [31:0] wdata = 0, rdata, pat = 0, ana = 0, unit = 0, seed = 32'h7111;
  logic [1:0] bresp, rresp, otw = 0, spo;
  logic [15:0] sht = 0, nvb = 0, nvd = 0, src, snk, ov, ex;
  logic [2:0] sup = 0;
  logic [255:0] pv;
  logic [23:0] baud;
  logic flamp, alamp;
  ifio_drive_t drv;
  int miscompares = 0, compares = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [23:0] rates[12] = '{24'h2580, 24'h4b00, 24'h9600, 24'he100, 24'h1c200, 24'h38400,
    24'h70800, 24'he1000, 24'h1312d0, 24'h2625a0, 24'h4c4b40, 24'h989680};
  always #12.5 aclk = ~aclk;
  ifio_field_model i_ifio_field_model (.lvl0(lvl0), .pat(pat), .in_pct_vec(pv));
  ifio_top i_ifio_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_level_pct(32'h0), .in_pct_vec(pv), .ana_in(ana), .short_trip(sht),
    .otemp_warn(otw), .field_supply_high(sup[0]), .field_supply_low(sup[1]),
    .field_supply_lost(sup[2]), .processor_supply_separate(sep),
    .field_supply_level(8'h42), .nv_baud_store(nvb), .nv_unit_store(unit),
    .nv_dog_store(nvd), .drive(drv), .spindle_out(spo), .spindle_enable(sp_en),
    .spindle_reverse(sp_rev), .field_fault_indicator(flamp),
    .field_activity_indicator(alamp), .baud_rate(baud));
  task check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    @(posedge aclk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
  endtask
  task rst;
    aresetn <= 0;
    cyc(16);
    aresetn <= 1;
    cyc(2);
  endtask
  task clr;
    wr(`IFIO_A_CLEAR, 32'h3f);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) check(bresp, bq.pop_front());
  end
  initial begin
    #2500000;
    miscompares++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 12; i++) begin
      nvb <= i[15:0];
      rst();
      cyc(2);
      check(baud, rates[i]);
    end
    $display("baud test done");
    nvb <= `IFIO_BAUD_DEF;
    nvd <= 16'h0001;
    unit <= $random(seed);
    rst();
    check(flamp, 1);
    check(alamp, 0);
    check(drv, 0);
    rd(`IFIO_A_FAULT, 32'h1);
    rd(`IFIO_A_DOG, 32'h1);
    rd(`IFIO_A_UNIT, unit);
    wr(`IFIO_A_OUT, 32'hffff);
    cyc(3);
    check(drv.hi_en, 0);
    clr();
    rd(`IFIO_A_FAULT, 32'h0);
    cyc(4);
    check(flamp, 0);
    $display("power-up test done");
    src = $random(seed);
    snk = $random(seed);
    ov = $random(seed);
    wr(`IFIO_A_SINK, snk);
    wr(`IFIO_A_SOURCE, src);
    wr(`IFIO_A_OUT, ov);
    cyc(3);
    ex = src & ov;
    check(drv.hi_en, ex);
    check(drv.lo_en, (snk & ~src & ov) | (snk & src & ~ov));
    sht <= 16'h0009;
    cyc(3);
    sht <= 0;
    rd(`IFIO_A_FAULT, 32'h2);
    check(drv.hi_en, ex & 16'hfff6);
    clr();
    otw <= 2'b10;
    cyc(3);
    otw <= 0;
    rd(`IFIO_A_FAULT, 32'h4);
    check(drv.hi_en, ex & 16'h00ff);
    clr();
    $display("output test done");
    pat <= $random(seed);
    foreach (rates[i]) begin
      if (i < 4) begin
        lvl0 <= (i == 0) ? 8'h37 : (i == 1) ? `IFIO_HYST_HI : (i == 2) ? 8'h2d : `IFIO_HYST_LO;
        cyc(3);
        rd(`IFIO_A_IN, {pat[31:1], i == 1 || i == 2});
      end
    end
    for (int m = 0; m < 8; m++) begin
      wr(`IFIO_A_SPIN, m[2]);
      sp_en <= m[0];
      sp_rev <= m[1];
      cyc(3);
      check(spo, m[2] ? {m[0] & m[1], m[0] & ~m[1]} : m[1:0]);
    end
    ana <= $random(seed);
    wr(`IFIO_A_PDMODE, 32'h0);
    rd(`IFIO_A_ANA01, 32'h0);
    wr(`IFIO_A_PDMODE, 32'h1);
    rd(`IFIO_A_ANA01, {16'h0, ana[15:0]});
    rd(`IFIO_A_ANA23, {16'h0, ana[31:16]});
    wr(`IFIO_A_PDMODE, 32'h2);
    rd(`IFIO_A_STATUS, 32'h4242_0200);
    wr(8'h44, 32'h1, 2'b10);
    rd(8'h44, 32'h0, 2'b10);
    sep <= 1;
    for (int k = 0; k < 3; k++) begin
      sup <= 3'h1 << k;
      cyc(3);
      sup <= 0;
      rd(`IFIO_A_FAULT, 32'h8 << k);
      clr();
    end
    $display("input test done");
    wr(`IFIO_A_OUT, 32'hffff);
    cyc(40100);
    rd(`IFIO_A_FAULT, 32'h1);
    check(drv.hi_en, 0);
    wr(`IFIO_A_DOG, 32'h0);
    clr();
    cyc(40100);
    rd(`IFIO_A_FAULT, 32'h0);
    $display("watchdog test done");
    cyc(2);
    test_done();
  end
endmodule // ifio_top_test
